// file: common/sse_pkg.sv
/*
  Package of the supply sequence state engine: register offsets, state
  definition word layout, timing constants and the engine state type.
  Assumes a 250 MHz system clock and a 32-bit classic Wishbone slave port.
*/
package sse_pkg;
  // Clock rate and derived time bases.
  localparam int CLK_MHZ          = 250;
  localparam int TICK_NS          = 10000;                    // Timer tick of 10 us.
  localparam int TICK_CYC         = TICK_NS * CLK_MHZ / 1000;
  localparam int FETCH_NS         = 20000;                    // State definition load time.
  localparam int FETCH_CYC_DFLT   = FETCH_NS * CLK_MHZ / 1000;

  // Counts of states and inputs.
  localparam int NUM_DEFS         = 64;                       // All 64 usable, none reserved.
  localparam int NUM_SUP          = 8;
  localparam int NUM_DIG          = 4;
  localparam int NUM_COND         = 13;                       // Supplies, digital inputs, warning.
  localparam int WARN_IDX         = 12;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_JUMP  = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [7:0] OFS_DRV   = 8'h0c;
  localparam logic [7:0] OFS_FLOW  = 8'h10;                   // fault_latch_low
  localparam logic [7:0] OFS_FHIGH = 8'h14;                   // fault_latch_high
  localparam logic [7:0] OFS_UV    = 8'h18;
  localparam logic [7:0] OFS_OV    = 8'h1c;
  localparam logic [7:0] OFS_ADC   = 8'h20;
  localparam logic [7:0] OFS_PADDR = 8'h24;
  localparam logic [7:0] OFS_PLO   = 8'h28;
  localparam logic [7:0] OFS_PHI   = 8'h2c;

  // Field positions inside the 64-bit state definition word.
  localparam int F_DRV    = 0;   // 8 driver output levels.
  localparam int F_SEQT   = 8;   // Sequence target state, 6 bits.
  localparam int F_TOT    = 14;  // Timeout target state, 6 bits.
  localparam int F_MONT   = 20;  // Monitor target state, 6 bits.
  localparam int F_SSEL   = 26;  // Sequence input select, 4 bits.
  localparam int F_SPOL   = 30;  // Sequence wanted level.
  localparam int F_LATCH  = 31;  // Fault latch enable.
  localparam int F_MMASK  = 32;  // Monitor input mask, 13 bits.
  localparam int F_MPOL   = 45;  // Monitor expected level.
  localparam int F_SDV    = 46;  // Sequence delay value, 6 bits.
  localparam int F_SDS    = 52;  // Sequence delay scale, 2 bits.
  localparam int F_TOV    = 54;  // Timeout value, 6 bits, zero means none.
  localparam int F_TOS    = 60;  // Timeout scale, 2 bits.
  localparam int F_TOWARN = 62;  // Timeout exit taken at once on a warning.

  // Tick multipliers: MUL0 to MUL3 for the four delay scales, MUL1 to MUL4 for timeouts.
  localparam logic [19:0] MUL0 = 20'h00001;
  localparam logic [19:0] MUL1 = 20'h0000a;
  localparam logic [19:0] MUL2 = 20'h00064;
  localparam logic [19:0] MUL3 = 20'h003e8;
  localparam logic [19:0] MUL4 = 20'h02710;

  // Engine control states.
  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_FETCH = 2'b01,
    ENG_RUN   = 2'b10
  } sse_eng_t;
endpackage

// file: common/sse_store_if.sv
/*
  Interface between the engine and its state definition store: a load
  request with its answer, and a program write port.
  Assumes both ends run on the one system clock.
*/
`timescale 1ns/1ps
interface sse_store_if;
  logic        reqValid;   // One-cycle load request.
  logic [5:0]  reqIndex;   // State to load.
  logic        rspValid;   // One-cycle answer with the word.
  logic [63:0] rspWord;    // Loaded state definition.
  logic        wrEn;       // One-cycle program write.
  logic [5:0]  wrIndex;    // State being programmed.
  logic [63:0] wrWord;     // New definition word.

  modport store  (input reqValid, reqIndex, wrEn, wrIndex, wrWord,
                  output rspValid, rspWord);
  modport engine (output reqValid, reqIndex, wrEn, wrIndex, wrWord,
                  input rspValid, rspWord);
endinterface

// file: rtl/sse_state_store.sv
/*
  Nonvolatile state definition store model with its load latency.
  Assumes one request at a time; a request while busy is ignored.
*/
`timescale 1ns/1ps
module sse_state_store #(
  parameter int FETCH_CYC = sse_pkg::FETCH_CYC_DFLT
) (
  // Clock and reset.
  input  wire logic   clk_sys,
  input  wire logic   srst,
  // Engine side.
  sse_store_if.store  port
);
  logic [63:0] defMem [sse_pkg::NUM_DEFS];  // Definition words.
  logic [15:0] waitCnt_reg, waitCnt_next;    // Remaining load cycles.
  logic        busy_reg,    busy_next;       // A load is under way.
  logic [5:0]  idx_reg,     idx_next;        // Index being loaded.
  logic        rsp_reg,     rsp_next;        // Answer pulse.
  logic [63:0] word_reg,    word_next;       // Answer word.

  // Count the load time, then hand the word over in one pulse.
  always_comb begin
    waitCnt_next = waitCnt_reg;
    busy_next    = busy_reg;
    idx_next     = idx_reg;
    rsp_next     = 1'b0;
    word_next    = word_reg;
    if (!busy_reg && port.reqValid) begin
      busy_next    = 1'b1;
      idx_next     = port.reqIndex;
      waitCnt_next = 16'(FETCH_CYC - 1);
    end else if (busy_reg) begin
      if (waitCnt_reg == 16'h0000) begin
        busy_next = 1'b0;
        rsp_next  = 1'b1;
        word_next = defMem[idx_reg];
      end else begin
        waitCnt_next = waitCnt_reg - 16'h0001;
      end
    end
  end

  // Register the load sequencer; the memory has no reset, like real storage.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      waitCnt_reg <= 16'h0000;
      busy_reg    <= 1'b0;
      idx_reg     <= 6'h00;
      rsp_reg     <= 1'b0;
      word_reg    <= 64'h0;
    end else begin
      waitCnt_reg <= waitCnt_next;
      busy_reg    <= busy_next;
      idx_reg     <= idx_next;
      rsp_reg     <= rsp_next;
      word_reg    <= word_next;
    end
    if (port.wrEn) begin
      defMem[port.wrIndex] <= port.wrWord;
    end
  end

  assign port.rspValid = rsp_reg;
  assign port.rspWord  = word_reg;
endmodule // sse_state_store

// file: rtl/sse_engine.sv
/*
  Supply sequence state engine with its Wishbone register slave, warning
  merge, fault latch and live status.
  Assumes inputs synchronous to clk_sys and comparators outside this block.
*/
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module sse_engine #(
  parameter int FETCH_CYC = sse_pkg::FETCH_CYC_DFLT  // Load latency in cycles.
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Supply monitors, digital inputs and warning sources.
  input  wire logic [7:0]  supUvIn,
  input  wire logic [7:0]  supOvIn,
  input  wire logic [3:0]  digIn,
  input  wire logic [7:0]  adcLimitIn,
  input  wire logic [3:0]  secWarnIn,
  input  wire logic        cfgDone,
  // Driver outputs.
  output logic      [7:0]  drvOut
);
  sse_store_if storeBus ();

  sse_state_store #(.FETCH_CYC(FETCH_CYC)) uStore (
    .clk_sys (clk_sys),
    .srst    (srst),
    .port    (storeBus.store)
  );

  // Turns a delay value and scale into 10 us ticks; timeouts use 100 us units.
  function automatic logic [19:0] toTicks(input logic [5:0] val, input logic [1:0] scl,
                                          input logic isTo);
    logic [19:0] mul;
    mul = MUL_SEL(scl, isTo);
    return 20'(val * mul);
  endfunction

  // Picks the multiplier for a scale code.
  function automatic logic [19:0] MUL_SEL(input logic [1:0] scl, input logic isTo);
    logic [19:0] m;
    case (scl)
      2'h0:    m = isTo ? sse_pkg::MUL1 : sse_pkg::MUL0;
      2'h1:    m = isTo ? sse_pkg::MUL2 : sse_pkg::MUL1;
      2'h2:    m = isTo ? sse_pkg::MUL3 : sse_pkg::MUL2;
      default: m = isTo ? sse_pkg::MUL4 : sse_pkg::MUL3;
    endcase
    return m;
  endfunction

  // Merges a write into a register under the byte enables.
  function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // Engine state.
  sse_pkg::sse_eng_t eng_reg,     eng_next;      // Control state.
  logic [5:0]  curState_reg,  curState_next;     // Current state number.
  logic [63:0] def_reg,       def_next;          // Loaded definition.
  logic [7:0]  drv_reg,       drv_next;          // Driver levels.
  logic [19:0] seqCnt_reg,    seqCnt_next;       // Sequence hold timer.
  logic [19:0] toCnt_reg,     toCnt_next;        // Timeout timer.
  logic [11:0] pre_reg,       pre_next;          // Tick prescaler.
  logic        jumpPend_reg,  jumpPend_next;     // Jump waiting to be taken.
  logic [5:0]  jumpTgt_reg,   jumpTgt_next;      // Jump destination.
  logic [7:0]  fault_reg,     fault_next;        // Fault latch.
  logic        warn_reg,      warn_next;         // Merged warning.
  logic [7:0]  uv_reg,        uv_next;           // Live undervoltage.
  logic [7:0]  ov_reg,        ov_next;           // Live overvoltage.
  logic [7:0]  adc_reg,       adc_next;          // Live ADC limit flags.
  logic [3:0]  sec_reg,       sec_next;          // Live secondary trips.
  logic        req_reg,       req_next;          // Load request pulse.
  logic [5:0]  reqIdx_reg,    reqIdx_next;       // Load request index.
  // Bus state.
  logic        ack_reg,       ack_next;          // Answer pulse.
  logic [31:0] rdat_reg,      rdat_next;         // Read data.
  logic [5:0]  pAddr_reg,     pAddr_next;        // Program index.
  logic [31:0] pLo_reg,       pLo_next;          // Program word low half.
  logic        wrEn_reg,      wrEn_next;         // Store write pulse.
  logic [31:0] wrHi_reg,      wrHi_next;         // Store write high half.
  // Decoded bus events, tick enable, condition inputs and exit conditions.
  logic        busWr;                            // Write accepted this cycle.
  logic        busRd;                            // Read accepted this cycle.
  logic        jumpWr;                           // Jump register written.
  logic [7:0]  faultClr;                         // Latch bits to clear.
  logic        tick;                             // 10 us enable.
  logic [12:0] cond;                             // Condition inputs.
  logic        seqHit, monHit, toHit;            // Exit conditions.

  // Bus decode: one answer per request, writes take effect at the answer.
  always_comb begin
    busWr     = wb_cyc_i && wb_stb_i && !ack_reg && wb_we_i;
    busRd     = wb_cyc_i && wb_stb_i && !ack_reg && !wb_we_i;
    jumpWr    = busWr && (wb_adr_i == sse_pkg::OFS_JUMP) && wb_sel_i[0];
    faultClr  = 8'h00;
    if (busWr && (wb_adr_i == sse_pkg::OFS_FLOW) && wb_sel_i[0]) begin
      faultClr[3:0] = wb_dat_i[3:0];
    end
    if (busWr && (wb_adr_i == sse_pkg::OFS_FHIGH) && wb_sel_i[0]) begin
      faultClr[7:4] = wb_dat_i[3:0];
    end
  end

  // Bus registers: read mux, program port and answer pulse.
  always_comb begin
    ack_next   = wb_cyc_i && wb_stb_i && !ack_reg;
    rdat_next  = rdat_reg;
    pAddr_next = pAddr_reg;
    pLo_next   = pLo_reg;
    wrEn_next  = 1'b0;
    wrHi_next  = wrHi_reg;
    if (busRd) begin
      case (wb_adr_i)
        sse_pkg::OFS_STATE: rdat_next = {24'h0, eng_reg, curState_reg};
        sse_pkg::OFS_DRV:   rdat_next = {24'h0, drv_reg};
        sse_pkg::OFS_FLOW:  rdat_next = {28'h0, fault_reg[3:0]};
        sse_pkg::OFS_FHIGH: rdat_next = {28'h0, fault_reg[7:4]};
        sse_pkg::OFS_UV:    rdat_next = {24'h0, uv_reg};
        sse_pkg::OFS_OV:    rdat_next = {24'h0, ov_reg};
        sse_pkg::OFS_ADC:   rdat_next = {19'h0, warn_reg, sec_reg, adc_reg};
        sse_pkg::OFS_JUMP:  rdat_next = {25'h0, jumpPend_reg, jumpTgt_reg};
        sse_pkg::OFS_PADDR: rdat_next = {26'h0, pAddr_reg};
        sse_pkg::OFS_PLO:   rdat_next = pLo_reg;
        sse_pkg::OFS_PHI:   rdat_next = wrHi_reg;
        default:            rdat_next = 32'h0;  // Unmapped reads answer zero.
      endcase
    end
    if (busWr) begin
      case (wb_adr_i)
        sse_pkg::OFS_PADDR: pAddr_next = 6'(byteMerge({26'h0, pAddr_reg}, wb_dat_i, wb_sel_i));
        sse_pkg::OFS_PLO:   pLo_next   = byteMerge(pLo_reg, wb_dat_i, wb_sel_i);
        sse_pkg::OFS_PHI: begin
          wrHi_next = byteMerge(wrHi_reg, wb_dat_i, wb_sel_i);
          wrEn_next = 1'b1;
        end
        default: ;  // Other writes are handled by the engine or ignored.
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_reg   <= 1'b0;
      rdat_reg  <= 32'h0;
      pAddr_reg <= 6'h00;
      pLo_reg   <= 32'h0;
      wrEn_reg  <= 1'b0;
      wrHi_reg  <= 32'h0;
    end else begin
      ack_reg   <= ack_next;
      rdat_reg  <= rdat_next;
      pAddr_reg <= pAddr_next;
      pLo_reg   <= pLo_next;
      wrEn_reg  <= wrEn_next;
      wrHi_reg  <= wrHi_next;
    end
  end

  // Condition vector: supply in tolerance, digital levels, merged warning.
  always_comb begin
    tick             = (pre_reg == 12'(sse_pkg::TICK_CYC - 1));
    cond             = 13'h0;
    cond[7:0]        = ~(uv_reg | ov_reg);
    cond[11:8]       = digIn;
    cond[sse_pkg::WARN_IDX] = warn_reg;
    seqHit = (cond[def_reg[sse_pkg::F_SSEL +: 4]] == def_reg[sse_pkg::F_SPOL])
             && (seqCnt_reg >= toTicks(def_reg[sse_pkg::F_SDV +: 6],
                                       def_reg[sse_pkg::F_SDS +: 2], 1'b0));
    monHit = |(def_reg[sse_pkg::F_MMASK +: 13]
               & (cond ^ {13{def_reg[sse_pkg::F_MPOL]}}));
    toHit  = ((def_reg[sse_pkg::F_TOV +: 6] != 6'h00)
              && (toCnt_reg >= toTicks(def_reg[sse_pkg::F_TOV +: 6],
                                       def_reg[sse_pkg::F_TOS +: 2], 1'b1)))
             || (def_reg[sse_pkg::F_TOWARN] && warn_reg);
  end

  // Engine: load, run, pick one of the three exits, load the target.
  always_comb begin
    eng_next      = eng_reg;
    curState_next = curState_reg;
    def_next      = def_reg;
    drv_next      = drv_reg;
    seqCnt_next   = seqCnt_reg;
    toCnt_next    = toCnt_reg;
    pre_next      = tick ? 12'h000 : pre_reg + 12'h001;
    jumpPend_next = jumpPend_reg;
    jumpTgt_next  = jumpTgt_reg;
    fault_next    = fault_reg & ~faultClr;
    warn_next     = (|adcLimitIn) || (|secWarnIn);
    uv_next       = supUvIn;
    ov_next       = supOvIn;
    adc_next      = adcLimitIn;
    sec_next      = secWarnIn;
    req_next      = 1'b0;
    reqIdx_next   = reqIdx_reg;
    if (jumpWr) begin
      jumpTgt_next  = wb_dat_i[5:0];
      jumpPend_next = 1'b1;
    end
    case (eng_reg)
      sse_pkg::ENG_IDLE: begin
        if (cfgDone) begin
          eng_next    = sse_pkg::ENG_FETCH;
          req_next    = 1'b1;
          reqIdx_next = 6'h00;
        end
      end
      sse_pkg::ENG_FETCH: begin
        // Old levels stay out while the next definition loads.
        if (storeBus.rspValid) begin
          eng_next      = sse_pkg::ENG_RUN;
          curState_next = reqIdx_reg;
          def_next      = storeBus.rspWord;
          drv_next      = storeBus.rspWord[sse_pkg::F_DRV +: 8];
          seqCnt_next   = 20'h0;
          toCnt_next    = 20'h0;
        end
      end
      sse_pkg::ENG_RUN: begin
        // Capture faults only while this state enables the latch.
        if (def_reg[sse_pkg::F_LATCH]) begin
          fault_next = fault_next | (uv_reg | ov_reg);
        end
        if (tick) begin
          seqCnt_next = seqCnt_reg + 20'h1;
          toCnt_next  = toCnt_reg + 20'h1;
        end
        // A moment off the wanted level starts the hold over.
        if (cond[def_reg[sse_pkg::F_SSEL +: 4]] != def_reg[sse_pkg::F_SPOL]) begin
          seqCnt_next = 20'h0;
        end
        // Jump first so software can always break out; then the three exits.
        if (jumpPend_reg && !jumpWr) begin
          jumpPend_next = 1'b0;
          eng_next      = sse_pkg::ENG_FETCH;
          req_next      = 1'b1;
          reqIdx_next   = jumpTgt_reg;
        end else if (monHit) begin
          eng_next    = sse_pkg::ENG_FETCH;
          req_next    = 1'b1;
          reqIdx_next = def_reg[sse_pkg::F_MONT +: 6];
        end else if (toHit) begin
          eng_next    = sse_pkg::ENG_FETCH;
          req_next    = 1'b1;
          reqIdx_next = def_reg[sse_pkg::F_TOT +: 6];
        end else if (seqHit) begin
          eng_next    = sse_pkg::ENG_FETCH;
          req_next    = 1'b1;
          reqIdx_next = def_reg[sse_pkg::F_SEQT +: 6];
        end
      end
      default: eng_next = sse_pkg::ENG_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      eng_reg      <= sse_pkg::ENG_IDLE;
      curState_reg <= 6'h00;
      def_reg      <= 64'h0;
      drv_reg      <= 8'h00;
      seqCnt_reg   <= 20'h0;
      toCnt_reg    <= 20'h0;
      pre_reg      <= 12'h000;
      jumpPend_reg <= 1'b0;
      jumpTgt_reg  <= 6'h00;
      fault_reg    <= 8'h00;
      warn_reg     <= 1'b0;
      uv_reg       <= 8'h00;
      ov_reg       <= 8'h00;
      adc_reg      <= 8'h00;
      sec_reg      <= 4'h0;
      req_reg      <= 1'b0;
      reqIdx_reg   <= 6'h00;
    end else begin
      eng_reg      <= eng_next;
      curState_reg <= curState_next;
      def_reg      <= def_next;
      drv_reg      <= drv_next;
      seqCnt_reg   <= seqCnt_next;
      toCnt_reg    <= toCnt_next;
      pre_reg      <= pre_next;
      jumpPend_reg <= jumpPend_next;
      jumpTgt_reg  <= jumpTgt_next;
      fault_reg    <= fault_next;
      warn_reg     <= warn_next;
      uv_reg       <= uv_next;
      ov_reg       <= ov_next;
      adc_reg      <= adc_next;
      sec_reg      <= sec_next;
      req_reg      <= req_next;
      reqIdx_reg   <= reqIdx_next;
    end
  end

  // Store connections; all come from flip-flops.
  assign storeBus.reqValid = req_reg;
  assign storeBus.reqIndex = reqIdx_reg;
  assign storeBus.wrEn     = wrEn_reg;
  assign storeBus.wrIndex  = pAddr_reg;
  assign storeBus.wrWord   = {wrHi_reg, pLo_reg};
  assign wb_ack_o          = ack_reg;
  assign wb_dat_o          = rdat_reg;
  assign drvOut            = drv_reg;
endmodule // sse_engine

// file: tb/sse_supply_model.sv
/* Far-side model: supply monitors, digital inputs and warning sources.
   Assumes the bench calls apply and nothing else drives these lines. */
`timescale 1ns/1ps
module sse_supply_model (
  // Clock.
  input  wire logic  clk_sys,
  // Levels seen by the engine.
  output logic [7:0] supUvIn,
  output logic [7:0] supOvIn,
  output logic [3:0] digIn,
  output logic [7:0] adcLimitIn,
  output logic [3:0] secWarnIn
);
  // All supplies start in tolerance so that no exit fires early.
  initial {supUvIn, supOvIn, digIn, adcLimitIn, secWarnIn} = '0;

  // New levels land just after an edge, as real comparators settle.
  task automatic apply(input logic [7:0] uv, ov, input logic [3:0] dig,
                       input logic [7:0] adc, input logic [3:0] sec);
    @(posedge clk_sys);
    {supUvIn, supOvIn, digIn} <= {uv, ov, dig};
    {adcLimitIn, secWarnIn}   <= {adc, sec};
  endtask
endmodule // sse_supply_model

// file: tb/sse_engine_sva.sv
/* Port checker of the supply sequence state engine.
   Assumes it is bound to sse_engine and sees only its ports. */
`timescale 1ns/1ps
module sse_engine_sva #(
  parameter int FETCH_CYC = sse_pkg::FETCH_CYC_DFLT  // Load latency in cycles.
) (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        srst,
  // Register bus.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Monitors and drivers.
  input wire logic [7:0]  supUvIn,
  input wire logic [7:0]  supOvIn,
  input wire logic [7:0]  adcLimitIn,
  input wire logic [3:0]  secWarnIn,
  input wire logic        cfgDone,
  input wire logic [7:0]  drvOut
);
  logic [7:0]  prevDrv;                   // Drivers one cycle ago.
  logic [27:0] prevIn;                    // Status inputs one cycle ago.
  int unsigned gap;                       // Cycles since drivers changed.
  int unsigned quiet;                     // Cycles the status inputs held.
  wire logic   rdAck = wb_ack_o && !wb_we_i;
  // Live status is only judged once inputs have settled past the pipeline.
  always_ff @(posedge clk_sys) begin
    prevDrv <= drvOut;
    prevIn  <= {supUvIn, supOvIn, adcLimitIn, secWarnIn};
    gap     <= (srst || drvOut != prevDrv) ? 0 : gap + 1;
    quiet   <= (srst || prevIn != {supUvIn, supOvIn, adcLimitIn, secWarnIn}) ? 0 : quiet + 1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
  property p_rst_out; $fell(srst) |-> drvOut == 8'h00 && !wb_ack_o; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
  property p_idle; !cfgDone |=> $stable(drvOut); endproperty
  a_idle: assert property (p_idle) else $error("drivers moved before download");
  property p_drv_gap; drvOut != prevDrv |-> gap >= FETCH_CYC; endproperty
  a_drv_gap: assert property (p_drv_gap) else $error("state change too fast");
  property p_uv_live;
    rdAck && wb_adr_i == sse_pkg::OFS_UV && quiet > 4 |-> wb_dat_o == 32'(supUvIn);
  endproperty
  a_uv_live: assert property (p_uv_live) else $error("undervoltage status wrong");
  property p_ov_live;
    rdAck && wb_adr_i == sse_pkg::OFS_OV && quiet > 4 |-> wb_dat_o == 32'(supOvIn);
  endproperty
  a_ov_live: assert property (p_ov_live) else $error("overvoltage status wrong");
  property p_warn;
    rdAck && wb_adr_i == sse_pkg::OFS_ADC && quiet > 4
      |-> wb_dat_o[12] == |{adcLimitIn, secWarnIn};
  endproperty
  a_warn: assert property (p_warn) else $error("warning merge wrong");
  c_load: cover property (drvOut != prevDrv);
  c_write: cover property (wb_ack_o && wb_we_i);
  c_uv: cover property (rdAck && wb_adr_i == sse_pkg::OFS_UV && quiet > 4);
endmodule // sse_engine_sva
bind sse_engine sse_engine_sva #(.FETCH_CYC(FETCH_CYC)) sse_engine_sva_i (.clk_sys, .srst,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .supUvIn, .supOvIn,
  .adcLimitIn, .secWarnIn, .cfgDone, .drvOut);

// file: tb/test_supply_sequence_state_engine.sv
/* Self-checking bench of the supply sequence state engine.
   Assumes the engine, its store, the supply model and checker alongside. */
`timescale 1ns/1ps
module test_supply_sequence_state_engine;
  localparam int FETCH = 20;          // Short load latency for simulation.
  logic        clk_sys;
  logic        srst      = 1'b1;      // Held ten cycles at start.
  logic        cfgDone   = 1'b0;      // Configuration download done.
  logic        req       = 1'b0;      // Bus cyc and stb move together.
  logic        wb_we_i   = 1'b0;
  logic [7:0]  wb_adr_i  = 8'h00;
  logic [3:0]  wb_sel_i  = 4'hf;      // Whole words only.
  logic [31:0] wb_dat_i  = 32'h0;
  logic [31:0] wb_dat_o, rdData;
  logic        wb_ack_o;
  logic [7:0]  supUvIn, supOvIn, adcLimitIn, drvOut;
  logic [3:0]  digIn, secWarnIn;
  int          numErrors = 0;
  int          testsRun  = 0;

  sse_engine #(.FETCH_CYC(FETCH)) sse_engine_i (.clk_sys, .srst, .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .supUvIn, .supOvIn, .digIn, .adcLimitIn, .secWarnIn, .cfgDone, .drvOut);
  sse_supply_model sse_supply_model_i (.clk_sys, .supUvIn, .supOvIn, .digIn, .adcLimitIn,
    .secWarnIn);

  // A 250 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled high; the next call idles a cycle.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {req, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, w, a, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 64);
    chk(32'(wb_ack_o), 32'h1);
    rdData = wb_dat_o;
    req <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdData, exp);
  endtask

  // A definition word goes low half first; the high half commits it.
  task automatic prog(input logic [5:0] idx, input logic [63:0] w);
    xfer(1'b1, sse_pkg::OFS_PADDR, 32'(idx));
    xfer(1'b1, sse_pkg::OFS_PLO, w[31:0]);
    xfer(1'b1, sse_pkg::OFS_PHI, w[63:32]);
  endtask

  // Waits, bounded, for a state's driver levels; a load takes FETCH plus two cycles,
  // and a timer exit may come up to one 10 us tick later than the caller's hold-off.
  task automatic waitDrv(input logic [7:0] exp);
    int n;
    n = 0;
    while (drvOut !== exp && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(drvOut), 32'(exp));
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic finishTest();
    $display("Comparisons %0d, mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // The whole run needs about thirty-five thousand cycles, most of them the timeout test.
  initial begin
    #200000;
    numErrors++;
    finishTest();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    prog(6'd0, 64'h0000_0000_e000_0101);
    prog(6'd1, 64'h0000_2001_7020_0303);
    prog(6'd2, 64'h0000_0000_6400_0007);
    prog(6'd3, 64'h0000_8000_6400_040f);
    prog(6'd4, 64'h0040_0000_2400_c01f);
    rd(8'h30, 32'h0);
    chk(32'(drvOut), 32'h0);
    cfgDone <= 1'b1;
    waitDrv(8'h01);
    rd(sse_pkg::OFS_STATE, 32'h80);
    sse_supply_model_i.apply(8'h01, 8'h00, 4'h0, 8'h00, 4'h0);
    settle();
    rd(sse_pkg::OFS_FLOW, 32'h1);
    sse_supply_model_i.apply(8'h00, 8'h00, 4'h0, 8'h00, 4'h0);
    settle();
    rd(sse_pkg::OFS_UV, 32'h0);
    rd(sse_pkg::OFS_FLOW, 32'h1);
    sse_supply_model_i.apply(8'h00, 8'h00, 4'h1, 8'h00, 4'h0);
    waitDrv(8'h03);
    xfer(1'b1, sse_pkg::OFS_FLOW, 32'h1);
    sse_supply_model_i.apply(8'h00, 8'h02, 4'h1, 8'h00, 4'h0);
    settle();
    rd(sse_pkg::OFS_FLOW, 32'h0);
    rd(sse_pkg::OFS_OV, 32'h2);
    sse_supply_model_i.apply(8'h01, 8'h02, 4'h1, 8'h00, 4'h1);
    waitDrv(8'h07);
    rd(sse_pkg::OFS_ADC, 32'h1100);
    sse_supply_model_i.apply(8'h01, 8'h02, 4'h1, 8'h80, 4'h0);
    settle();
    rd(sse_pkg::OFS_ADC, 32'h1080);
    xfer(1'b1, sse_pkg::OFS_JUMP, 32'h3);
    waitDrv(8'h0f);
    rd(sse_pkg::OFS_STATE, 32'h83);
    // Each one-cycle drop restarts the two-tick hold; held time adds up to more than two ticks.
    repeat (3) begin
      sse_supply_model_i.apply(8'h01, 8'h02, 4'h1, 8'h80, 4'h0);
      sse_supply_model_i.apply(8'h01, 8'h02, 4'h3, 8'h80, 4'h0);
      repeat (2400) @(posedge clk_sys);
    end
    chk(32'(drvOut), 32'h0f);
    waitDrv(8'h1f);
    // The timeout of ten ticks cannot have run out before nine whole ticks.
    repeat (22400) @(posedge clk_sys);
    chk(32'(drvOut), 32'h1f);
    waitDrv(8'h0f);
    finishTest();
  end
endmodule // test_supply_sequence_state_engine
